// >>> ims_defines.svh
/*
 * Register indices, byte addresses, field positions, codes, widths and reset
 * values of the ingress mirror selection block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef IMS_DEFINES_SVH
`define IMS_DEFINES_SVH

`define IMS_IDX_CAPT     8'h10
`define IMS_IDX_CTRL     8'h12
`define IMS_IDX_DIV      8'h14
`define IMS_IDX_MAC_LO   8'h16
`define IMS_IDX_MAC_HI   8'h17
`define IMS_IDX_STAT     8'h18
`define IMS_ADDR_CAPT    (`IMS_IDX_CAPT * 8'h04)
`define IMS_ADDR_CTRL    (`IMS_IDX_CTRL * 8'h04)
`define IMS_ADDR_DIV     (`IMS_IDX_DIV * 8'h04)
`define IMS_ADDR_MAC_LO  (`IMS_IDX_MAC_LO * 8'h04)
`define IMS_ADDR_MAC_HI  (`IMS_IDX_MAC_HI * 8'h04)
`define IMS_ADDR_STAT    (`IMS_IDX_STAT * 8'h04)

`define IMS_REG_W        16
`define IMS_DIV_W        10
`define IMS_MAC_W        48
`define IMS_PORT_W       4
`define IMS_CNT_W        16

`define IMS_SEL_HI       15
`define IMS_SEL_LO       14
`define IMS_THIN_BIT     13
`define IMS_MASK_TOP     4'h8
`define IMS_EN_BIT       15
`define IMS_BLK_BIT      14
`define IMS_CPORT_HI     3

`define IMS_SEL_ALL      2'h0
`define IMS_SEL_DA       2'h1
`define IMS_SEL_SA       2'h2
`define IMS_SEL_RSVD     2'h3

`define IMS_CTRL_RST     16'h0000
`define IMS_CAPT_RST     16'h0000
`define IMS_CAPT_WMASK   16'hC00F
`define IMS_DIV_RST      10'h000
`define IMS_MAC_RST      48'h000000000000

`define IMS_RESP_OKAY    2'h0
`define IMS_RESP_SLVERR  2'h2

`endif

// >>> ims_pkg.sv
/*
 * Types of the ingress mirror selection block: bus states and the state record.
 * Assumes the constants header is reachable by bare name.
 */
package ims_pkg;
`include "ims_defines.svh"

    typedef enum logic [1:0] {
        IMS_WS_IDLE = 2'b01,
        IMS_WS_RESP = 2'b10
    } ims_wst_t;

    typedef enum logic [1:0] {
        IMS_RS_IDLE = 2'b01,
        IMS_RS_DATA = 2'b10
    } ims_rdst_t;

    typedef struct packed {
        ims_wst_t                 wst;
        ims_rdst_t                rdst;
        logic                     aw_held;
        logic                     w_held;
        logic [7:0]               awaddr;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic [1:0]               bresp;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
        logic [`IMS_REG_W-1:0]    ctrl;
        logic [`IMS_REG_W-1:0]    capt;
        logic [`IMS_DIV_W-1:0]    div;
        logic [`IMS_MAC_W-1:0]    mac;
        logic [`IMS_DIV_W-1:0]    thin_cnt;
        logic [`IMS_CNT_W-1:0]    copy_cnt;
        logic [`IMS_CNT_W-1:0]    pass_cnt;
    } ims_state_t;
endpackage

// >>> ims_fifo.sv
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock, an active-low asynchronous reset and a power-of-two depth.
 */
`timescale 1ns/1ps
`default_nettype none

module ims_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    output logic [$clog2(DEPTH):0]        level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } ims_fifo_state_t;

    ims_fifo_state_t s_r;
    ims_fifo_state_t s_nxt;
    logic            push;
    logic            pop;

    assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign level     = s_r.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

`default_nettype wire

// >>> ims_ingress_mirror_select.sv
/*
 * Ingress mirror selection: decides which received frames are copied to the
 * capture port, with its AXI4-Lite register slave and an 8-word copy FIFO.
 * Assumes frame descriptors come from logic on ref_clk, and that the
 * forwarding path treats each descriptor independently of this block.
 */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ims_defines.svh"

module ims_ingress_mirror_select #(
    parameter int TAG_W      = 16,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    rx_valid,
    output logic                         rx_ready,
    input  wire logic [3:0]              rx_port,
    input  wire logic [47:0]             rx_da,
    input  wire logic [47:0]             rx_sa,
    input  wire logic [TAG_W-1:0]        rx_tag,
    output logic                         cap_valid,
    input  wire logic                    cap_ready,
    output logic [TAG_W-1:0]             cap_tag,
    output logic [3:0]                   cap_src_port,
    output logic [3:0]                   cap_dest_port,
    output logic                         cap_block_normal
);
    import ims_pkg::*;

    localparam int FW = TAG_W + `IMS_PORT_W;

    // ------------------------------------------------------------
    // Reset release.
    // ------------------------------------------------------------
    logic rs1_r;
    logic rs2_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] din,
                                           input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = din[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [32:0] reg_read(input ims_state_t st,
                                             input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        case (a)
            `IMS_ADDR_CAPT:   r[15:0] = st.capt;
            `IMS_ADDR_CTRL:   r[15:0] = st.ctrl;
            `IMS_ADDR_DIV:    r[9:0]  = st.div;
            `IMS_ADDR_MAC_LO: r[31:0] = st.mac[31:0];
            `IMS_ADDR_MAC_HI: r[15:0] = st.mac[47:32];
            `IMS_ADDR_STAT:   r[31:0] = {st.pass_cnt, st.copy_cnt};
            default:          r       = {1'b0, 32'h00000000};
        endcase
        return r;
    endfunction

    ims_state_t        s_r;
    ims_state_t        s_nxt;
    logic              aw_fire_c;
    logic              w_fire_c;
    logic              ar_fire_c;
    logic              wr_do_c;
    logic [7:0]        wr_addr_c;
    logic [31:0]       wr_data_c;
    logic [3:0]        wr_strb_c;
    logic [32:0]       wr_old_c;
    logic [31:0]       wr_val_c;
    logic [32:0]       rd_c;
    logic              ar_ctrl_c;
    logic [1:0]        sel_c;
    logic              en_c;
    logic              thin_en_c;
    logic              mask_hit_c;
    logic              pass_c;
    logic              cand_c;
    logic              thin_hit_c;
    logic              copy_c;
    logic              rx_fire_c;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic [FW-1:0]     fifo_out_data;

    // ------------------------------------------------------------
    // Register slave handshakes.
    // ------------------------------------------------------------
    assign s_axi_awready = (s_r.wst == IMS_WS_IDLE) && !s_r.aw_held;
    assign s_axi_wready  = (s_r.wst == IMS_WS_IDLE) && !s_r.w_held;
    assign s_axi_arready = (s_r.rdst == IMS_RS_IDLE);
    assign s_axi_bvalid  = (s_r.wst == IMS_WS_RESP);
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_rvalid  = (s_r.rdst == IMS_RS_DATA);
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

    assign aw_fire_c = s_axi_awvalid && s_axi_awready;
    assign w_fire_c  = s_axi_wvalid && s_axi_wready;
    assign ar_fire_c = s_axi_arvalid && s_axi_arready;
    assign ar_ctrl_c = ar_fire_c && (s_axi_araddr == `IMS_ADDR_CTRL);
    assign wr_do_c   = (s_r.wst == IMS_WS_IDLE) && (s_r.aw_held || aw_fire_c)
                       && (s_r.w_held || w_fire_c);
    assign wr_addr_c = s_r.aw_held ? s_r.awaddr : s_axi_awaddr;
    assign wr_data_c = s_r.w_held ? s_r.wdata : s_axi_wdata;
    assign wr_strb_c = s_r.w_held ? s_r.wstrb : s_axi_wstrb;
    assign wr_old_c  = reg_read(s_r, wr_addr_c);
    assign wr_val_c  = wmerge(wr_old_c[31:0], wr_data_c, wr_strb_c);
    assign rd_c      = reg_read(s_r, s_axi_araddr);

    // ------------------------------------------------------------
    // Frame selection.
    // ------------------------------------------------------------
    assign sel_c      = s_r.ctrl[`IMS_SEL_HI:`IMS_SEL_LO];
    assign en_c       = s_r.capt[`IMS_EN_BIT];
    assign thin_en_c  = s_r.ctrl[`IMS_THIN_BIT];
    assign mask_hit_c = (rx_port <= `IMS_MASK_TOP) && s_r.ctrl[rx_port];
    assign thin_hit_c = !thin_en_c || (s_r.thin_cnt >= s_r.div);
    assign cand_c     = en_c && mask_hit_c && pass_c;
    assign copy_c     = cand_c && thin_hit_c;
    assign rx_fire_c  = rx_valid && rx_ready;

    always_comb begin
        case (sel_c)
            `IMS_SEL_ALL: pass_c = 1'b1;
            `IMS_SEL_DA:  pass_c = (rx_da == s_r.mac);
            `IMS_SEL_SA:  pass_c = (rx_sa == s_r.mac);
            default:      pass_c = 1'b0;
        endcase
    end

    assign fifo_in_valid    = rx_valid && copy_c;
    assign rx_ready         = fifo_in_ready || !copy_c;
    assign cap_dest_port    = s_r.capt[`IMS_CPORT_HI:0];
    assign cap_block_normal = en_c && s_r.capt[`IMS_BLK_BIT];
    assign cap_tag          = fifo_out_data[TAG_W-1:0];
    assign cap_src_port     = fifo_out_data[FW-1:TAG_W];

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (aw_fire_c) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr  = s_axi_awaddr;
        end
        if (w_fire_c) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata  = s_axi_wdata;
            s_nxt.wstrb  = s_axi_wstrb;
        end
        case (s_r.wst)
            IMS_WS_IDLE: begin
                if (wr_do_c) begin
                    s_nxt.aw_held = 1'b0;
                    s_nxt.w_held  = 1'b0;
                    s_nxt.wst     = IMS_WS_RESP;
                    s_nxt.bresp   = wr_old_c[32] ? `IMS_RESP_OKAY : `IMS_RESP_SLVERR;
                    case (wr_addr_c)
                        `IMS_ADDR_CAPT:   s_nxt.capt = wr_val_c[15:0] & `IMS_CAPT_WMASK;
                        `IMS_ADDR_CTRL:   s_nxt.ctrl = wr_val_c[15:0];
                        `IMS_ADDR_DIV:    s_nxt.div  = wr_val_c[9:0];
                        `IMS_ADDR_MAC_LO: s_nxt.mac[31:0]  = wr_val_c;
                        `IMS_ADDR_MAC_HI: s_nxt.mac[47:32] = wr_val_c[15:0];
                        default:          s_nxt.bresp = s_nxt.bresp;
                    endcase
                end
            end
            IMS_WS_RESP: begin
                if (s_axi_bready) begin
                    s_nxt.wst = IMS_WS_IDLE;
                end
            end
            default: s_nxt.wst = IMS_WS_IDLE;
        endcase
        case (s_r.rdst)
            IMS_RS_IDLE: begin
                if (ar_fire_c) begin
                    s_nxt.rdst  = IMS_RS_DATA;
                    s_nxt.rdata = rd_c[31:0];
                    s_nxt.rresp = rd_c[32] ? `IMS_RESP_OKAY : `IMS_RESP_SLVERR;
                end
            end
            IMS_RS_DATA: begin
                if (s_axi_rready) begin
                    s_nxt.rdst = IMS_RS_IDLE;
                end
            end
            default: s_nxt.rdst = IMS_RS_IDLE;
        endcase
        // Thinning counts only frames that reached the filter output.
        if (rx_fire_c && cand_c) begin
            s_nxt.pass_cnt = s_r.pass_cnt + 16'h0001;
            if (thin_en_c && !thin_hit_c) begin
                s_nxt.thin_cnt = s_r.thin_cnt + 10'h001;
            end else begin
                s_nxt.thin_cnt = 10'h000;
            end
        end
        if (rx_fire_c && copy_c) begin
            s_nxt.copy_cnt = s_r.copy_cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rs2_r) begin
        if (!rs2_r) begin
            s_r          <= '0;
            s_r.wst      <= IMS_WS_IDLE;
            s_r.rdst     <= IMS_RS_IDLE;
            s_r.ctrl     <= `IMS_CTRL_RST;
            s_r.capt     <= `IMS_CAPT_RST;
            s_r.div      <= `IMS_DIV_RST;
            s_r.mac      <= `IMS_MAC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Copy FIFO.
    // ------------------------------------------------------------
    ims_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .rst_n     (rs2_r),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({rx_port, rx_tag}),
        .out_valid (cap_valid),
        .out_ready (cap_ready),
        .out_data  (fifo_out_data),
        .level     ()
    );

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rs2_r);

    chk_rsvd_code:
        assert property (sel_c == `IMS_SEL_RSVD |-> !fifo_in_valid)
        else $error("Reserved select code let a frame through.");
    chk_pass_all:
        assert property (sel_c == `IMS_SEL_ALL && en_c && mask_hit_c
                         && !thin_en_c && rx_valid |-> fifo_in_valid)
        else $error("Frame on selected port not copied in pass-all mode.");
    chk_da_match:
        assert property (sel_c == `IMS_SEL_DA && fifo_in_valid |-> rx_da == s_r.mac)
        else $error("Frame copied without destination match.");
    chk_sa_match:
        assert property (sel_c == `IMS_SEL_SA && fifo_in_valid |-> rx_sa == s_r.mac)
        else $error("Frame copied without source match.");
    chk_thin_off:
        assert property (rx_fire_c && cand_c && !thin_en_c |-> copy_c)
        else $error("Filtered frame dropped with thinning off.");
    chk_thin_ratio:
        assert property (rx_fire_c && cand_c && thin_en_c && !copy_c
                         |=> s_r.thin_cnt == $past(s_r.thin_cnt) + 10'h001)
        else $error("Thinning counter did not advance.");
    chk_thin_wrap:
        assert property (rx_fire_c && copy_c |=> s_r.thin_cnt == 10'h000)
        else $error("Thinning counter not cleared after a copy.");
    chk_mask_gate:
        assert property (fifo_in_valid |-> rx_port <= `IMS_MASK_TOP && s_r.ctrl[rx_port])
        else $error("Copy from a port outside the mask.");
    chk_fwd_free:
        assert property (rx_valid && !copy_c |-> rx_ready)
        else $error("Uncopied frame held back by the copy FIFO.");
    chk_glob_en:
        assert property (!en_c |-> !fifo_in_valid)
        else $error("Copy while mirroring is disabled.");
    chk_dest_write:
        assert property ($changed(cap_dest_port) |-> $past(wr_do_c))
        else $error("Capture port changed without a register write.");
    chk_copy_cnt:
        assert property (rx_fire_c && copy_c |=> s_r.copy_cnt == $past(s_r.copy_cnt) + 16'h0001)
        else $error("Copy counter missed a copy.");
    chk_ctrl_rdbk:
        assert property ($past(ar_ctrl_c) |-> s_axi_rdata == {16'h0000, $past(s_r.ctrl)})
        else $error("Control register read back wrong.");
    chk_reset_zero:
        assert property (!$past(rs2_r) |-> s_r.ctrl == `IMS_CTRL_RST && !cap_valid)
        else $error("Control not cleared after reset.");

    cov_da_copy:   cover property (rx_fire_c && copy_c && sel_c == `IMS_SEL_DA);
    cov_thin_skip: cover property (rx_fire_c && cand_c && !copy_c);
    cov_fifo_full: cover property (rx_valid && !fifo_in_ready);
    cov_cpu_port:  cover property (rx_fire_c && copy_c && rx_port == `IMS_MASK_TOP);
endmodule

`default_nettype wire

// >>> ims_far_end.sv
/*
 * Capture-port sink: takes mirrored descriptors and keeps their tags in order.
 * Assumes the block's clock and reset; stall holds ready low to back up the copy FIFO.
 */
`timescale 1ns/1ps
`default_nettype none

module ims_far_end (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        stall,
    input  wire logic        cap_valid,
    output var logic         cap_ready,
    input  wire logic [3:0]  cap_src_port,
    input  wire logic [15:0] cap_tag
);
    logic [19:0] got [$];

    // Ready follows the inverse of stall one cycle late; a tag is kept on each handshake.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_ready <= 1'b0;
        end else begin
            if (cap_valid && cap_ready) begin
                got.push_back({cap_src_port, cap_tag});
            end
            cap_ready <= !stall;
        end
    end
endmodule

`default_nettype wire

// >>> tb.sv
/*
 * Testbench of the ingress mirror selection block: reset and register checks, a row
 * table of filter cases, then register, enable, thinning, back-pressure and reset tests.
 * Assumes the constants header and the capture-port sink model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ims_defines.svh"

module tb;
    import ims_pkg::*;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [3:0]  port;
        logic        da_hit;
        logic        sa_hit;
        logic        cp;
    } ims_row_t;
    localparam logic [47:0] MAC = 48'h0A0B0C0D0E0F;
    localparam logic [47:0] OTH = 48'h11110C0D0E0F;
    logic ref_clk = 0, rst_n = 0, stall = 0, cap_ready;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, rx_ready, cap_valid, blk;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rdv;
    logic [3:0]  wstrb = 4'hF, rx_port = 0, src, dest;
    logic [1:0]  bresp, rresp, rsp;
    logic        rx_valid = 0;
    logic [47:0] rx_da = 0, rx_sa = 0;
    logic [15:0] rx_tag = 0, cap_tag;
    logic [19:0] exp_q [$];
    int num_errors = 0, n_checks = 0;
    ims_row_t rows [9] = '{
        '{16'h0001, 4'h0, 1'b0, 1'b0, 1'b1},
        '{16'h0001, 4'h1, 1'b0, 1'b0, 1'b0},
        '{16'h0100, 4'h8, 1'b0, 1'b0, 1'b1},
        '{16'h4020, 4'h5, 1'b1, 1'b0, 1'b1},
        '{16'h4020, 4'h5, 1'b0, 1'b1, 1'b0},
        '{16'h8020, 4'h5, 1'b0, 1'b1, 1'b1},
        '{16'h8020, 4'h5, 1'b1, 1'b0, 1'b0},
        '{16'hC03F, 4'h0, 1'b1, 1'b1, 1'b0},
        '{16'h1E03, 4'h1, 1'b0, 1'b0, 1'b1}
    };

    ims_ingress_mirror_select i_ims_ingress_mirror_select (
        .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_port(rx_port), .rx_da(rx_da),
        .rx_sa(rx_sa), .rx_tag(rx_tag), .cap_valid(cap_valid), .cap_ready(cap_ready),
        .cap_tag(cap_tag), .cap_src_port(src), .cap_dest_port(dest),
        .cap_block_normal(blk));
    ims_far_end i_ims_far_end (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
        .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_src_port(src),
        .cap_tag(cap_tag));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rdv = rdata;
        rsp = rresp;
        rready <= 0;
    endtask

    task automatic send(input logic [3:0] p, input logic [47:0] da, input logic [47:0] sa,
                        input logic [15:0] t);
        @(posedge ref_clk);
        rx_valid <= 1; rx_port <= p; rx_da <= da; rx_sa <= sa; rx_tag <= t;
        do @(posedge ref_clk); while (!rx_ready);
        rx_valid <= 0;
    endtask

    task automatic cmp_q();
        repeat (20) @(posedge ref_clk);
        check("copy count", i_ims_far_end.got.size(), exp_q.size());
        foreach (exp_q[i]) check("copy tag", i_ims_far_end.got[i], exp_q[i]);
        i_ims_far_end.got.delete();
        exp_q.delete();
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        #400000;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1;
        repeat (3) @(posedge ref_clk);
        rd(`IMS_ADDR_CTRL); check("ctrl reset", rdv, 32'h0000_0000);
        rd(`IMS_ADDR_CAPT); check("capt reset", rdv, 32'h0000_0000);
        check("dest reset", dest, 4'h0);
        wr(`IMS_ADDR_CAPT, 32'h0000_C007);
        check("dest", dest, 4'h7);
        check("block", blk, 1'b1);
        check("wr resp", rsp, `IMS_RESP_OKAY);
        wr(`IMS_ADDR_MAC_LO, 32'h0C0D_0E0F);
        wr(`IMS_ADDR_MAC_HI, 32'h0000_0A0B);
        wr(`IMS_ADDR_CAPT, 32'h0000_8003);
        foreach (rows[i]) begin
            wr(`IMS_ADDR_CTRL, {16'h0000, rows[i].ctrl});
            send(rows[i].port, rows[i].da_hit ? MAC : OTH, rows[i].sa_hit ? MAC : OTH, i);
            if (rows[i].cp) exp_q.push_back({rows[i].port, 16'(i)});
        end
        cmp_q();
        wr(`IMS_ADDR_CTRL, 32'h0000_1E00);
        rd(`IMS_ADDR_CTRL); check("ctrl readback", rdv, 32'h0000_1E00);
        rd(8'h7C); check("unmapped resp", rsp, `IMS_RESP_SLVERR);
        wr(8'h7C, 32'h0000_FFFF); check("unmapped wr", rsp, `IMS_RESP_SLVERR);
        wr(`IMS_ADDR_CAPT, 32'h0000_0003);
        wr(`IMS_ADDR_CTRL, 32'h0000_0001);
        send(4'h0, OTH, OTH, 16'd100);
        cmp_q();
        // Heavy port thinned to one in three frames.
        wr(`IMS_ADDR_CAPT, 32'h0000_8003);
        wr(`IMS_ADDR_DIV, 32'h0000_0002);
        wr(`IMS_ADDR_CTRL, 32'h0000_2001);
        for (int k = 0; k < 6; k++) send(4'h0, OTH, OTH, 16'd200 + k);
        exp_q = '{16'd202, 16'd205};
        cmp_q();
        wr(`IMS_ADDR_DIV, 32'h0000_0000);
        wr(`IMS_ADDR_CTRL, 32'h0000_2001);
        stall <= 1;
        for (int k = 0; k < 8; k++) begin
            send(4'h0, OTH, OTH, 16'd300 + k);
            exp_q.push_back(16'd300 + k);
        end
        @(posedge ref_clk);
        check("fifo full", rx_ready, 1'b0);
        send(4'h1, OTH, OTH, 16'd400);
        check("fwd free", rx_ready, 1'b1);
        stall <= 0;
        send(4'h0, OTH, OTH, 16'd308);
        exp_q.push_back(16'd308);
        cmp_q();
        rst_n <= 0;
        repeat (2) @(posedge ref_clk);
        check("dest mid reset", dest, 4'h0);
        rst_n <= 1;
        repeat (3) @(posedge ref_clk);
        rd(`IMS_ADDR_CTRL); check("ctrl mid reset", rdv, 32'h0000_0000);
        test_done();
    end
endmodule

`default_nettype wire
